// ### verilog/jtid_defs.vh
// Constants of the test access port: instruction codes, word layouts, timing
`ifndef JTID_DEFS_VH
`define JTID_DEFS_VH

// Instruction register
`define JTID_IR_W          4
`define JTID_DR_W          32
`define JTID_IR_EXTEST     4'h0
`define JTID_IR_SAMPLE     4'h1
`define JTID_IR_DEVICE_IDENTIFICATION_WORD     4'h2
`define JTID_IR_USERCODE   4'h3
`define JTID_IR_CHIPTAP    4'h4
`define JTID_IR_OTPACC     4'h5
`define JTID_IR_BYPASS     4'hF
`define JTID_IR_CAPTURE    4'h1

// TAP states, one-hot
`define JTID_ST_W          16
`define JTID_TLR           16'h0001
`define JTID_RTI           16'h0002
`define JTID_SDRS          16'h0004
`define JTID_CDR           16'h0008
`define JTID_SDR           16'h0010
`define JTID_E1DR          16'h0020
`define JTID_PDR           16'h0040
`define JTID_E2DR          16'h0080
`define JTID_UDR           16'h0100
`define JTID_SIRS          16'h0200
`define JTID_CIR           16'h0400
`define JTID_SIR           16'h0800
`define JTID_E1IR          16'h1000
`define JTID_PIR           16'h2000
`define JTID_E2IR          16'h4000
`define JTID_UIR           16'h8000

// Identification word fields
`define JTID_ID_VER_HI     31
`define JTID_ID_VER_LO     28
`define JTID_ID_PART_HI    27
`define JTID_ID_PART_LO    12
`define JTID_ID_MFR_HI     11
`define JTID_ID_MFR_LO     1
`define JTID_ID_ONE        0

// User code word fields and security register bits
`define JTID_UC_TAG_HI     31
`define JTID_UC_TAG_LO     22
`define JTID_UC_REV_HI     15
`define JTID_UC_REV_LO     0
`define JTID_SEC_TAG_HI    31
`define JTID_SEC_TAG_LO    22
`define JTID_SEC_NOJTAG    0
`define JTID_SEC_NOOTP     13

// Timing
`define JTID_CLK_PERIOD_NS 10
`define JTID_LOCK_WAIT_NS  2000

`endif

// ### verilog/jtid_sync3.v
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module jtid_sync3 #(
  parameter       W   = 1,
  parameter [0:0] RST = 1'h0
) (
  input  wire         clock,
  input  wire         reset,
  input  wire [W-1:0] din,
  output reg  [W-1:0] dout
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  // First stage feeds only the second
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      s1_r <= {W{RST}};
      s2_r <= {W{RST}};
      s3_r <= {W{RST}};
      dout <= {W{RST}};
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
      dout <= (s2_r & s3_r) | (dout & (s2_r | s3_r));
    end
  end
endmodule
`default_nettype wire

// ### verilog/jtid_tap.v
// Test access port with identification, user code and inner chip TAP path
`timescale 1ns/10ps
`default_nettype none
`include "jtid_defs.vh"
module jtid_tap #(
  parameter        BSC_N      = 8,
  parameter [3:0]  VERSION    = 4'h0,     // Arbitrary
  parameter [15:0] PART_NUM   = 16'h0A5C, // Arbitrary
  parameter [10:0] MFR_ID     = 11'h155,  // Arbitrary
  parameter [15:0] SI_REV     = 16'h0001,
  parameter        LOCK_WAIT  = (`JTID_LOCK_WAIT_NS + `JTID_CLK_PERIOD_NS - 1) /
                                `JTID_CLK_PERIOD_NS
) (
  input  wire             clock,
  input  wire             reset,
  input  wire             rst_n_pin,
  input  wire             tck,
  input  wire             tms,
  input  wire             tdi,
  input  wire             trst_n,
  output reg              tdo_o,
  output reg              tdo_oe,
  input  wire [31:0]      sec_reg,
  input  wire             otp_programmed,
  input  wire             pll_locked,
  output reg              boot_go,
  input  wire [BSC_N-1:0] pin_in,
  output reg  [BSC_N-1:0] pin_drive,
  output reg              extest_on,
  output reg              chip_tck,
  output reg              chip_tms,
  output reg              chip_tdi,
  input  wire             chip_tdo,
  output reg              otp_req,
  output reg  [31:0]      otp_word
);
  // Pins pass four flops; a change counts once stages two and three agree
  wire [4:0] sy;
  wire       s_tck  = sy[0];
  wire       s_tms  = sy[1];
  wire       s_tdi  = sy[2];
  wire       s_trst = sy[3];
  wire       s_rst  = sy[4];
  jtid_sync3 #(.W(5), .RST(1'h0)) u_sync (
    .clock (clock),
    .reset (reset),
    .din   ({rst_n_pin, trst_n, tdi, tms, tck}),
    .dout  (sy)
  );
  reg        tck_d_r;
  wire       rise = s_tck & ~tck_d_r;
  wire       fall = ~s_tck & tck_d_r;

  // ======================================================
  // Global reset and boot sequencing
  reg [31:0] lock_cnt_r;
  // Asynchronous global reset; pin assertion acts immediately via OR
  wire       g_rst = reset | ~rst_n_pin;
  always @(posedge clock or posedge g_rst) begin
    if (g_rst) begin
      lock_cnt_r <= 32'h0;
      boot_go    <= 1'h0;
    end else begin
      // Count lock stable before booting
      if (!s_rst || !pll_locked)
        lock_cnt_r <= 32'h0;
      else if (lock_cnt_r < LOCK_WAIT)
        lock_cnt_r <= lock_cnt_r + 32'h1;
      else
        boot_go <= 1'h1;
    end
  end

  // ======================================================
  // Controller
  reg [`JTID_ST_W-1:0] st_r;
  reg [`JTID_ST_W-1:0] st_nxt;
  // Sixteen-state walk on rising test clock
  always @* begin
    case (st_r)
      `JTID_TLR:  st_nxt = s_tms ? `JTID_TLR  : `JTID_RTI;
      `JTID_RTI:  st_nxt = s_tms ? `JTID_SDRS : `JTID_RTI;
      `JTID_SDRS: st_nxt = s_tms ? `JTID_SIRS : `JTID_CDR;
      `JTID_CDR:  st_nxt = s_tms ? `JTID_E1DR : `JTID_SDR;
      `JTID_SDR:  st_nxt = s_tms ? `JTID_E1DR : `JTID_SDR;
      `JTID_E1DR: st_nxt = s_tms ? `JTID_UDR  : `JTID_PDR;
      `JTID_PDR:  st_nxt = s_tms ? `JTID_E2DR : `JTID_PDR;
      `JTID_E2DR: st_nxt = s_tms ? `JTID_UDR  : `JTID_SDR;
      `JTID_UDR:  st_nxt = s_tms ? `JTID_SDRS : `JTID_RTI;
      `JTID_SIRS: st_nxt = s_tms ? `JTID_TLR  : `JTID_CIR;
      `JTID_CIR:  st_nxt = s_tms ? `JTID_E1IR : `JTID_SIR;
      `JTID_SIR:  st_nxt = s_tms ? `JTID_E1IR : `JTID_SIR;
      `JTID_E1IR: st_nxt = s_tms ? `JTID_UIR  : `JTID_PIR;
      `JTID_PIR:  st_nxt = s_tms ? `JTID_E2IR : `JTID_PIR;
      `JTID_E2IR: st_nxt = s_tms ? `JTID_UIR  : `JTID_SIR;
      `JTID_UIR:  st_nxt = s_tms ? `JTID_SDRS : `JTID_RTI;
      default:    st_nxt = `JTID_TLR;
    endcase
  end

  // Decodes shared by several selectors
  function is_ir;
    input [`JTID_IR_W-1:0] ir;
    input [`JTID_IR_W-1:0] code;
    begin
      is_ir = (ir == code);
    end
  endfunction

  reg [`JTID_IR_W-1:0] ir_r;
  reg [`JTID_IR_W-1:0] ir_sh_r;
  reg [`JTID_DR_W-1:0] dr_r;
  reg [BSC_N-1:0]      bsr_r;

  // Security gating of tile and fuse paths
  wire no_tile = sec_reg[`JTID_SEC_NOJTAG];
  wire no_otp  = sec_reg[`JTID_SEC_NOJTAG] | sec_reg[`JTID_SEC_NOOTP];
  wire sel_bs  = is_ir(ir_r, `JTID_IR_EXTEST) | is_ir(ir_r, `JTID_IR_SAMPLE);
  wire sel_ch  = is_ir(ir_r, `JTID_IR_CHIPTAP) & ~no_tile;
  wire sel_otp = is_ir(ir_r, `JTID_IR_OTPACC) & ~no_otp;

  // Word fields; tag zero when fuses unprogrammed
  wire [9:0]  tag     = otp_programmed ?
                        sec_reg[`JTID_SEC_TAG_HI:`JTID_SEC_TAG_LO] : 10'h000;
  wire [31:0] id_word = {VERSION, PART_NUM, MFR_ID, 1'h1};
  wire [31:0] uc_word = {tag, 6'h00, SI_REV};
  wire [31:0] dr_cap  = is_ir(ir_r, `JTID_IR_DEVICE_IDENTIFICATION_WORD)   ? id_word :
                        is_ir(ir_r, `JTID_IR_USERCODE) ? uc_word :
                        sel_otp ? otp_word : 32'h0;

  // ======================================================
  // Shift path; state, instruction and boundary registers held in reset while test reset low
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      tck_d_r   <= 1'h0;
      st_r      <= `JTID_TLR;
      ir_r      <= `JTID_IR_DEVICE_IDENTIFICATION_WORD;
      ir_sh_r   <= `JTID_IR_W'h0;
      dr_r      <= `JTID_DR_W'h0;
      bsr_r     <= {BSC_N{1'h0}};
    end else begin
      tck_d_r   <= s_tck;
      if (!s_trst) begin
        st_r  <= `JTID_TLR;
        ir_r  <= `JTID_IR_DEVICE_IDENTIFICATION_WORD;
        bsr_r <= {BSC_N{1'h0}};
      end else if (rise) begin
        st_r <= st_nxt;
        if (st_r == `JTID_TLR)
          ir_r <= `JTID_IR_DEVICE_IDENTIFICATION_WORD;
        if (st_r == `JTID_CIR)
          ir_sh_r <= `JTID_IR_CAPTURE;
        if (st_r == `JTID_SIR)
          ir_sh_r <= {s_tdi, ir_sh_r[`JTID_IR_W-1:1]};
        if (st_r == `JTID_UIR)
          ir_r <= ir_sh_r;
        if (st_r == `JTID_CDR) begin
          dr_r <= dr_cap;
          if (sel_bs)
            bsr_r <= pin_in;
        end
        if (st_r == `JTID_SDR) begin
          dr_r <= {s_tdi, dr_r[`JTID_DR_W-1:1]};
          if (sel_bs)
            bsr_r <= {s_tdi, bsr_r[BSC_N-1:1]};
        end
      end
    end
  end

  // ======================================================
  // Registered outputs; data out moves on falling test clock
  wire shifting = (st_r == `JTID_SDR) | (st_r == `JTID_SIR);
  wire tdo_bit  = (st_r == `JTID_SIR) ? ir_sh_r[0] :
                  sel_ch ? chip_tdo :
                  sel_bs ? bsr_r[0] :
                  is_ir(ir_r, `JTID_IR_BYPASS) ? 1'h0 : dr_r[0];
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      tdo_o     <= 1'h0;
      tdo_oe    <= 1'h0;
      pin_drive <= {BSC_N{1'h0}};
      extest_on <= 1'h0;
      chip_tck  <= 1'h0;
      chip_tms  <= 1'h1;
      chip_tdi  <= 1'h0;
      otp_req   <= 1'h0;
      otp_word  <= 32'h0;
    end else begin
      if (fall) begin
        tdo_o  <= tdo_bit;
        tdo_oe <= shifting & s_trst;
      end
      // Enable drops at once in test reset, not at the next fall
      if (!s_trst)
        tdo_oe <= 1'h0;
      // Update stage of boundary scan
      if (rise && st_r == `JTID_UDR && is_ir(ir_r, `JTID_IR_EXTEST))
        pin_drive <= bsr_r;
      extest_on <= s_trst & is_ir(ir_r, `JTID_IR_EXTEST);
      // Inner chip TAP follows pins only while selected and permitted
      chip_tck <= sel_ch & s_trst & s_tck;
      chip_tms <= ~(sel_ch & s_trst) | s_tms;
      chip_tdi <= sel_ch & s_tdi;
      // Fuse access pulse on update; blocked by security
      otp_req  <= rise & (st_r == `JTID_UDR) & sel_otp & s_trst;
      if (rise && st_r == `JTID_UDR && sel_otp)
        otp_word <= dr_r;
    end
  end
endmodule
`default_nettype wire

// ### verif/jtid_chk_assertions.sv
// Concurrent checks on the test access port pins
`timescale 1ns/10ps
`default_nettype none
module jtid_chk (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        rst_n_pin,
  input wire logic        tck,
  input wire logic        trst_n,
  input wire logic        tdo_o,
  input wire logic        tdo_oe,
  input wire logic [31:0] sec_reg,
  input wire logic        pll_locked,
  input wire logic        boot_go,
  input wire logic        extest_on,
  input wire logic        chip_tck,
  input wire logic        chip_tms,
  input wire logic        chip_tdi,
  input wire logic        otp_req
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // ==========================================
  // Properties
  property p_trst_quiet; !trst_n [*8] |-> !tdo_oe && !extest_on; endproperty
  a_trst_quiet: assert property (p_trst_quiet) else $error("port active in test reset");
  property p_trst_chip; !trst_n [*8] |-> chip_tms && !chip_tck && !chip_tdi; endproperty
  a_trst_chip: assert property (p_trst_chip) else $error("inner port not idle");
  property p_rst_boot; !rst_n_pin |-> !boot_go; endproperty
  a_rst_boot: assert property (p_rst_boot) else $error("boot while reset low");
  property p_boot_lock; $rose(boot_go) |-> $past(pll_locked, 2) && rst_n_pin; endproperty
  a_boot_lock: assert property (p_boot_lock) else $error("boot without lock");
  // Lock bits held two cycles so a late change of the register is not blamed
  property p_sec0; sec_reg[0] && $past(sec_reg[0], 2) |-> !otp_req; endproperty
  a_sec0: assert property (p_sec0) else $error("fuse access while port locked");
  property p_sec13; sec_reg[13] && $past(sec_reg[13], 2) |-> !otp_req; endproperty
  a_sec13: assert property (p_sec13) else $error("fuse access while blocked");
  property p_tdo_fall; $changed(tdo_o) |-> !$past(tck, 4); endproperty
  a_tdo_fall: assert property (p_tdo_fall) else $error("data out moved off fall");
  property p_oe_rise; $rose(tdo_oe) |-> !$past(tck, 4); endproperty
  a_oe_rise: assert property (p_oe_rise) else $error("enable rose off fall");
  c_boot: cover property ($rose(boot_go));
  c_shift: cover property ($rose(tdo_oe));
  c_trst: cover property ($fell(trst_n));
  c_otp: cover property ($rose(otp_req));
endmodule
bind jtid_tap jtid_chk u_chk (.clock(clock), .reset(reset), .rst_n_pin(rst_n_pin),
  .tck(tck), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .sec_reg(sec_reg),
  .pll_locked(pll_locked), .boot_go(boot_go), .extest_on(extest_on),
  .chip_tck(chip_tck), .chip_tms(chip_tms), .chip_tdi(chip_tdi), .otp_req(otp_req));
`default_nettype wire

// ### verif/jtid_host.sv
// Behavioural test host driving the port pins
`timescale 1ns/10ps
`default_nettype none
module jtid_host (
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  output logic     trst_n,
  input wire logic tdo
);
  // ==========================================
  // Pin steps, clock still between frames
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
    trst_n = 1'h0;
  end
  task automatic step(input logic m, input logic d, output logic q);
    tms = m;
    tdi = d;
    #80 q = tdo;
    tck = 1'h1;
    #80 tck = 1'h0;
  endtask
  task automatic test_reset(input int ns);
    trst_n = 1'h0;
    #(ns) trst_n = 1'h1;
  endtask
  // From idle to shift, n bits LSB first, back to idle
  task automatic scan(input logic ir, input logic [31:0] din, input int n,
                      output logic [31:0] q);
    logic b;
    int   i;
    step(1'h1, 1'h0, b);
    if (ir) step(1'h1, 1'h0, b);
    step(1'h0, 1'h0, b);
    step(1'h0, 1'h0, b);
    q = 32'h0;
    for (i = 0; i < n; i++) begin
      step(i == n - 1, din[i], b);
      q[i] = b;
    end
    step(1'h1, 1'h0, b);
    step(1'h0, 1'h0, b);
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
// Self-checking bench for the test access port
`timescale 1ns/10ps
`default_nettype none
`include "jtid_defs.vh"
module tb_top;
  // Arbitrary identity values
  localparam logic [3:0]  VER  = 4'h3;
  localparam logic [15:0] PART = 16'h1234;
  localparam logic [10:0] MFR  = 11'h2AA;
  localparam logic [31:0] ID   = {VER, PART, MFR, 1'h1};
  logic        clock = 1'h0;
  logic        reset = 1'h1;
  logic        rst_n_pin = 1'h0;
  logic        otp_prog = 1'h0;
  logic        pll_locked = 1'h0;
  logic        chip_tdo = 1'h0;
  logic [31:0] sec_reg = 32'h0;
  logic [31:0] rnd = 32'h39;
  logic [31:0] seen;
  logic [31:0] exp_q[$];
  wire         tck, tms, tdi, trst_n, tdo_o, boot_go;
  wire [7:0]   pin_drive;
  int          fails = 0;
  int          num_checks = 0;
  event        ev_res;
  always #5 clock = ~clock;
  jtid_host u_host (.tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo(tdo_o));
  jtid_tap #(.BSC_N(8), .VERSION(VER), .PART_NUM(PART), .MFR_ID(MFR), .SI_REV(16'h0001),
    .LOCK_WAIT(2)) u_dut (.clock(clock), .reset(reset), .rst_n_pin(rst_n_pin),
    .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n), .tdo_o(tdo_o), .tdo_oe(),
    .sec_reg(sec_reg), .otp_programmed(otp_prog), .pll_locked(pll_locked),
    .boot_go(boot_go), .pin_in(rnd[7:0]), .pin_drive(pin_drive), .extest_on(), .chip_tck(),
    .chip_tms(), .chip_tdi(), .chip_tdo(chip_tdo), .otp_req(), .otp_word());
  // ==========================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] word expected %h seen %h", e, g);
    end
  endtask
  task automatic note(input logic [31:0] e, input logic [31:0] g);
    exp_q.push_back(e);
    seen = g;
    -> ev_res;
  endtask
  task automatic drive(input logic [31:0] s, input logic p);
    @(posedge clock);
    #1 sec_reg = s;
    otp_prog = p;
  endtask
  // Instruction capture always reads 0001
  task automatic read(input logic ld, input logic [3:0] code, input logic [31:0] e);
    logic [31:0] q;
    if (ld) begin
      u_host.scan(1'h1, {28'h0, code}, 4, q);
      note(32'h1, q);
    end
    u_host.scan(1'h0, 32'h0, 32, q);
    note(e, q);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ==========================================
  // Result monitor and watchdog
  initial forever @(ev_res) chk(exp_q.pop_front(), seen);
  initial begin
    // Run needs about 120 us; generous margin for slow steps
    #400000 fails++;
    conclude();
  end
  // ==========================================
  // Scenarios
  initial begin
    logic [31:0] s;
    logic        b;
    repeat (12) @(posedge clock);
    #1 reset = 1'h0;
    note(32'h0, {31'h0, boot_go});
    @(posedge clock);
    #1 rst_n_pin = 1'h1;
    pll_locked = 1'h1;
    repeat (20) @(posedge clock);
    #1 note(32'h1, {31'h0, boot_go});
    u_host.test_reset(120);
    u_host.step(1'h0, 1'h0, b);
    read(1'h0, 4'h0, ID);
    read(1'h1, `JTID_IR_DEVICE_IDENTIFICATION_WORD, ID);
    repeat (3) begin
      rnd = xs(rnd);
      s = rnd & 32'hFFFFDFFE;
      drive(s, 1'h1);
      read(1'h1, `JTID_IR_USERCODE, {s[31:22], 6'h00, 16'h0001});
    end
    drive(32'hFFC00000, 1'h0);
    read(1'h1, `JTID_IR_USERCODE, 32'h00000001);
    chip_tdo = 1'h1;
    drive(32'h0, 1'h1);
    read(1'h1, `JTID_IR_CHIPTAP, 32'hFFFFFFFF);
    drive(32'h1, 1'h1);
    read(1'h1, `JTID_IR_CHIPTAP, 32'h0);
    // Fuse word written, blocked writes tried, then read back
    drive(32'h0, 1'h1);
    u_host.scan(1'h1, {28'h0, `JTID_IR_OTPACC}, 4, s);
    note(32'h1, s);
    u_host.scan(1'h0, rnd, 32, s);
    drive(32'h2000, 1'h1);
    u_host.scan(1'h0, ~rnd, 32, s);
    note(32'h0, s);
    drive(32'h1, 1'h1);
    u_host.scan(1'h0, ~rnd, 32, s);
    note(32'h0, s);
    drive(32'h0, 1'h1);
    read(1'h0, 4'h0, rnd);
    read(1'h1, 4'h9, 32'h0);
    read(1'h1, `JTID_IR_BYPASS, 32'h0);
    // Boundary scan: captured pins come out first, last eight shifted bits land on pins
    rnd = xs(rnd);
    u_host.scan(1'h1, {28'h0, `JTID_IR_EXTEST}, 4, s);
    note(32'h1, s);
    u_host.scan(1'h0, rnd, 32, s);
    note({rnd[23:0], rnd[7:0]}, s);
    #1 note({24'h0, rnd[31:24]}, {24'h0, pin_drive});
    u_host.test_reset(120);
    u_host.step(1'h0, 1'h0, b);
    read(1'h0, 4'h0, ID);
    @(posedge clock);
    #1 rst_n_pin = 1'h0;
    #1 note(32'h0, {31'h0, boot_go});
    #20 conclude();
  end
endmodule
`default_nettype wire
